// ### tcx_cmp_model.sv
// compare unit stand-in: one trigger pulse as the count reaches the period value
`timescale 1ns/1ps
module tcx_cmp_model (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                armed,
  input  wire tcx_pkg::tcx_count_t period,
  input  wire tcx_pkg::tcx_count_t countValue,
  output logic                     compareMatch
);
  import tcx_pkg::*;
  logic hitReg;
  wire  hitNext = armed && (countValue == period);
  // pulse only on the first cycle of each match episode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hitReg       <= 1'b0;
      compareMatch <= 1'b0;
    end else begin
      hitReg       <= hitNext;
      compareMatch <= hitNext && !hitReg;
    end
  end
endmodule

// ### tcx_defines.svh
// register offsets, field positions, reset values and codes for the 16-bit timer/counter
`ifndef TCX_DEFINES_SVH
`define TCX_DEFINES_SVH
`define TCX_OFF_CTRL      4'h0
`define TCX_OFF_LOW       4'h4
`define TCX_OFF_HIGH      4'h8
`define TCX_OFF_FLAG      4'hc
`define TCX_CTRL_RUN      0
`define TCX_CTRL_SRC      1
`define TCX_CTRL_NOSYNC   2
`define TCX_CTRL_OSCEN    3
`define TCX_CTRL_PS_LO    4
`define TCX_CTRL_PS_HI    5
`define TCX_CTRL_WIDE     7
`define TCX_CTRL_MASK     8'hbf
`define TCX_CTRL_RESET    8'h00
`define TCX_FLAG_OVF      0
`define TCX_FLAG_IRQEN    1
`define TCX_CMP_TRIG_MODE 4'hb
`define TCX_PS_1          2'h0
`define TCX_PS_2          2'h1
`define TCX_PS_4          2'h2
`define TCX_PS_8          2'h3
`define TCX_INSTR_DIV     2'h3
`define TCX_COUNT_ZERO    16'h0000
`define TCX_COUNT_MAX     16'hffff
`define TCX_RESP_OKAY     2'h0
`define TCX_RESP_SLVERR   2'h2
`endif

// ### tcx_pkg.sv
// types shared by the 16-bit timer/counter
package tcx_pkg;
  typedef logic [7:0]  tcx_byte_t;
  typedef logic [15:0] tcx_count_t;
  typedef logic [1:0]  tcx_resp_t;
endpackage

// ### tcx_timer.sv
// 16-bit timer/counter with prescaler, buffered wide access and compare trigger reset
// Behaviour
// - 16-bit count wraps FFFFh to 0000h
// - wrap sets sticky overflow flag, irq gated
// - control bit 0 runs or stops counting
// - bit 1 picks instruction clock or pin edges
// - bits 5:4 pick prescale 1,2,4,8
// - bit 2 bypasses external clock synchroniser
// - oscillator enable makes pins inputs reading 0
// - oscillator keeps running during sleep
// - bit 7 selects 16-bit or 8-bit access
// - low read copies high byte to buffer
// - low write loads high from buffer
// - wide mode high byte only via buffer
// - only low-byte writes clear the prescaler
// - compare trigger mode 1011 zeroes count, starts conversion
// - trigger reset never sets overflow flag
// - simultaneous write beats trigger reset
// - compare pair acts as period value
// - control bit 6 reads zero
// - count bytes not cleared by reset
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tcx_defines.svh"

module tcx_timer #(
  parameter int ADDR_W = 4
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output tcx_pkg::tcx_resp_t       s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output tcx_pkg::tcx_resp_t       s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                extCountClockPin,
  input  wire logic                crystalInPin,
  input  wire logic [1:0]          portPinIn,
  input  wire logic [1:0]          portDirectionReg,
  input  wire logic [3:0]          compareModeField,
  input  wire logic                compareMatch,
  input  wire logic                sleepMode,
  output logic [1:0]               portReadValue,
  output logic [1:0]               portPinInputOnly,
  output logic                     crystalOscRunning,
  output logic                     conversionStart,
  output logic                     overflowIrq,
  output tcx_pkg::tcx_count_t      countValue
);
  import tcx_pkg::*;

  // control, count and flag state
  tcx_byte_t  ctrl_reg;
  tcx_count_t count_reg;
  tcx_byte_t  highBuf_reg;
  logic       ovfFlag_reg;
  logic       ovfIrqEn_reg;
  logic [2:0] prescale_reg;
  logic [1:0] instrDiv_reg;
  logic       extSync1_reg;
  logic       extSync2_reg;
  logic       extPrev_reg;
  logic       extRawPrev_reg;

  // axi state
  logic [ADDR_W-1:0] awAddr_reg;
  logic              awHeld_reg;
  tcx_byte_t         wData_reg;
  logic              wStrb0_reg;
  logic              wHeld_reg;

  // control field decode
  wire logic       runEn     = ctrl_reg[`TCX_CTRL_RUN];
  wire logic       srcExt    = ctrl_reg[`TCX_CTRL_SRC];
  wire logic       noSync    = ctrl_reg[`TCX_CTRL_NOSYNC];
  wire logic       oscEn     = ctrl_reg[`TCX_CTRL_OSCEN];
  wire logic [1:0] psSel     = ctrl_reg[`TCX_CTRL_PS_HI:`TCX_CTRL_PS_LO];
  wire logic       wideMode  = ctrl_reg[`TCX_CTRL_WIDE];

  // external source: crystal input when enabled, else the count pin
  wire logic extRaw   = oscEn ? crystalInPin : extCountClockPin;
  // sync path rising edge, or raw rising edge when bypassed
  wire logic syncEdge = extSync2_reg & ~extPrev_reg;
  wire logic rawEdge  = extRaw & ~extRawPrev_reg;
  wire logic extTick  = noSync ? rawEdge : syncEdge;
  wire logic instrTick = (instrDiv_reg == `TCX_INSTR_DIV);
  wire logic srcTick  = srcExt ? extTick : instrTick;

  // prescaler output: ratio selected by the two prescale bits
  wire logic [2:0] psPlus  = prescale_reg + 3'h1;
  wire logic psDone =
    (psSel == `TCX_PS_1) ? 1'b1 :
    (psSel == `TCX_PS_2) ? (psPlus[0] == 1'b0) :
    (psSel == `TCX_PS_4) ? (psPlus[1:0] == 2'h0) :
                           (psPlus == 3'h0);
  wire logic countTick = runEn & srcTick & psDone;
  wire logic wrapNow   = countTick & (count_reg == `TCX_COUNT_MAX);

  // compare special event trigger in mode 1011; compare pair is period
  // only dependable with internal or synchronised counting
  wire logic trigReset = compareMatch & (compareModeField == `TCX_CMP_TRIG_MODE);

  // write channel decode
  wire logic doWrite  = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire logic wrHit    = doWrite & wStrb0_reg;
  wire logic wrCtrl   = wrHit & (awAddr_reg == ADDR_W'(`TCX_OFF_CTRL));
  wire logic wrLow    = wrHit & (awAddr_reg == ADDR_W'(`TCX_OFF_LOW));
  wire logic wrHigh   = wrHit & (awAddr_reg == ADDR_W'(`TCX_OFF_HIGH));
  wire logic wrFlag   = wrHit & (awAddr_reg == ADDR_W'(`TCX_OFF_FLAG));
  wire logic wrMapped = (awAddr_reg == ADDR_W'(`TCX_OFF_CTRL)) |
                        (awAddr_reg == ADDR_W'(`TCX_OFF_LOW)) |
                        (awAddr_reg == ADDR_W'(`TCX_OFF_HIGH)) |
                        (awAddr_reg == ADDR_W'(`TCX_OFF_FLAG));
  // a count write this cycle: low byte, or true high byte in narrow mode
  wire logic countWritten = wrLow | (wrHigh & ~wideMode);

  // read channel decode
  wire logic doRead  = s_axi_arvalid & s_axi_arready;
  wire logic rdCtrl  = (s_axi_araddr == ADDR_W'(`TCX_OFF_CTRL));
  wire logic rdLow   = (s_axi_araddr == ADDR_W'(`TCX_OFF_LOW));
  wire logic rdHigh  = (s_axi_araddr == ADDR_W'(`TCX_OFF_HIGH));
  wire logic rdFlag  = (s_axi_araddr == ADDR_W'(`TCX_OFF_FLAG));
  wire logic rdMapped = rdCtrl | rdLow | rdHigh | rdFlag;
  // wide mode reads the buffer, narrow mode the true high byte
  wire tcx_byte_t highView = wideMode ? highBuf_reg : count_reg[15:8];
  wire tcx_byte_t rdByte =
    rdCtrl ? (ctrl_reg & `TCX_CTRL_MASK) :
    rdLow  ? count_reg[7:0] :
    rdHigh ? highView :
    rdFlag ? {6'h00, ovfIrqEn_reg, ovfFlag_reg} : 8'h00;

  // next count: write wins over trigger, trigger over counting
  tcx_count_t countNext;
  always_comb begin
    countNext = count_reg;
    if (wrLow) begin
      countNext[7:0] = wData_reg;
      if (wideMode)
        countNext[15:8] = highBuf_reg;
    end else if (wrHigh && !wideMode) begin
      countNext[15:8] = wData_reg;
    end else if (trigReset) begin
      countNext = `TCX_COUNT_ZERO;
    end else if (countTick) begin
      countNext = count_reg + 16'h0001;
    end
  end

  // counter holds no reset so it survives controller resets
  // power-up contents are unknown until software writes both bytes
  always_ff @(posedge core_clk) begin
    count_reg <= countNext;
  end

  // high byte buffer: loaded by wide low reads and wide high writes
  always_ff @(posedge core_clk) begin
    if (doRead && rdLow && wideMode)
      highBuf_reg <= count_reg[15:8];
    else if (wrHigh && wideMode)
      highBuf_reg <= wData_reg;
  end

  // control register: bit 6 is never stored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      ctrl_reg <= `TCX_CTRL_RESET;
    else if (wrCtrl)
      ctrl_reg <= wData_reg & `TCX_CTRL_MASK;
  end

  // overflow interrupt enable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      ovfIrqEn_reg <= 1'b0;
    else if (wrFlag)
      ovfIrqEn_reg <= wData_reg[`TCX_FLAG_IRQEN];
  end

  // overflow flag: a wrap beats a software clear; a trigger or count write cannot set it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      ovfFlag_reg <= 1'b0;
    else if (wrapNow && !countWritten && !trigReset)
      ovfFlag_reg <= 1'b1;
    else if (wrFlag)
      ovfFlag_reg <= wData_reg[`TCX_FLAG_OVF];
  end

  // instruction clock: one tick every fourth core clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      instrDiv_reg <= 2'h0;
    else
      instrDiv_reg <= instrDiv_reg + 2'h1;
  end

  // two-flop synchroniser and edge history of the external source
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extSync1_reg   <= 1'b0;
      extSync2_reg   <= 1'b0;
      extPrev_reg    <= 1'b0;
      extRawPrev_reg <= 1'b0;
    end else begin
      extSync1_reg   <= extRaw;
      extSync2_reg   <= extSync1_reg;
      extPrev_reg    <= extSync2_reg;
      extRawPrev_reg <= extRaw;
    end
  end

  // prescaler: cleared only by low-byte count writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      prescale_reg <= 3'h0;
    else if (wrLow)
      prescale_reg <= 3'h0;
    else if (runEn && srcTick)
      prescale_reg <= psDone ? 3'h0 : psPlus;
  end

  // write address holding register: taken in either order with the data
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end
  end

  // write data holding register: only the low byte lane is used
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wHeld_reg  <= 1'b0;
      wData_reg  <= 8'h00;
      wStrb0_reg <= 1'b0;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg  <= 1'b1;
      wData_reg  <= s_axi_wdata[7:0];
      wStrb0_reg <= s_axi_wstrb[0];
    end
  end

  // write response: raised as the held pair is applied, held until bready
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TCX_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? `TCX_RESP_OKAY : `TCX_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // write readies: accept when no item of that channel is held and no write response is pending
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~awHeld_reg & ~(s_axi_awvalid & s_axi_awready) & ~doWrite
                       & ~s_axi_bvalid;
      s_axi_wready  <= ~wHeld_reg & ~(s_axi_wvalid & s_axi_wready) & ~doWrite
                       & ~s_axi_bvalid;
    end
  end

  // read ready: one read in flight at a time
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= ~s_axi_rvalid & ~doRead;
  end

  // axi read: one-cycle answer after the address is taken
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TCX_RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rdByte};
      s_axi_rresp  <= rdMapped ? `TCX_RESP_OKAY : `TCX_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pin view: oscillator enable forces both pins to inputs reading 0
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      portReadValue     <= 2'h0;
      portPinInputOnly  <= 2'h0;
      crystalOscRunning <= 1'b0;
    end else begin
      portReadValue     <= oscEn ? 2'h0 : portPinIn;
      portPinInputOnly  <= oscEn ? 2'h3 : ~portDirectionReg;
      crystalOscRunning <= oscEn; // sleepMode does not stop it
    end
  end

  // conversion start: one pulse per trigger that no count write overrode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      conversionStart <= 1'b0;
    else
      conversionStart <= trigReset & ~countWritten;
  end

  // interrupt request and count mirror, both one cycle behind
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      overflowIrq <= 1'b0;
      countValue  <= `TCX_COUNT_ZERO;
    end else begin
      overflowIrq <= ovfFlag_reg & ovfIrqEn_reg;
      countValue  <= count_reg;
    end
  end

  wire logic unusedIn = sleepMode;

endmodule

// ### tcx_timer_sva.sv
// port-level assertion checker for the 16-bit timer/counter
`timescale 1ns/1ps
module tcx_timer_sva (
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire tcx_pkg::tcx_resp_t  s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [3:0]          compareModeField,
  input wire logic                compareMatch,
  input wire logic                conversionStart,
  input wire logic                crystalOscRunning,
  input wire logic [1:0]          portReadValue,
  input wire logic [1:0]          portPinInputOnly,
  input wire tcx_pkg::tcx_count_t countValue
);
  import tcx_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // bus answers and held responses
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  // pins, trigger and count behaviour
  a_osc_pins: assert property (crystalOscRunning && $past(crystalOscRunning) |->
    portReadValue == 2'h0 && portPinInputOnly == 2'h3) else $error("osc pins not inputs");
  a_conv_pulse: assert property (conversionStart |=> !conversionStart)
    else $error("conversion pulse too long");
  a_conv_cause: assert property ($rose(conversionStart) |->
    $past(compareMatch) || $past(compareMatch, 2)) else $error("conversion without trigger");
  a_trig_zero: assert property (compareMatch && compareModeField == 4'hb &&
    !s_axi_bvalid && !$past(s_axi_wvalid) |-> ##2 countValue <= 16'h0001)
    else $error("trigger did not clear count");
  a_count_step: assert property ($past(resetn) && $past(resetn, 2) &&
    !$stable(countValue) |-> countValue == $past(countValue) + 16'h0001
    || $past(s_axi_bvalid) || $past(compareMatch) || $past(compareMatch, 2))
    else $error("count jumped");
endmodule
bind tcx_timer tcx_timer_sva tcx_timer_sva_inst (.*);

// ### tcx_timer_tb.sv
// self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
`include "tcx_defines.svh"
module tcx_timer_tb;
  import tcx_pkg::*;
  logic        core_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, extCountClockPin, crystalInPin, compareMatch, sleepMode, armed;
  logic        crystalOscRunning, conversionStart, overflowIrq;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, compareModeField;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  portPinIn, portDirectionReg, portReadValue, portPinInputOnly;
  tcx_resp_t   s_axi_bresp, s_axi_rresp, rr;
  tcx_count_t  countValue, period, c0;
  int          n_errors, n_tests, nConv;
  tcx_timer tcx_timer_inst (.*);
  tcx_cmp_model tcx_cmp_model_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!tb) begin
      @(negedge core_clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    repeat (2) @(negedge core_clk);
  endtask
  // bus read
  task automatic rdr(input logic [3:0] a);
    logic ta, tv;
    tv = 1'b0;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!tv) begin
      @(negedge core_clk);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] exp);
    rdr(a);
    chk(nm, rd, {24'h0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, extCountClockPin, crystalInPin} = '0;
    {portPinIn, sleepMode, armed, period, compareModeField} = '0;
    portDirectionReg = 2'h1;
    portPinIn = 2'h2;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rc("ctrl reset", `TCX_OFF_CTRL, 8'h00);
    rdr(4'h2);
    chk("unmapped", {30'h0, rr}, 32'h2);
    wr(`TCX_OFF_CTRL, 8'hff);
    rc("ctrl bit6", `TCX_OFF_CTRL, 8'hbf);
    s_axi_wstrb <= 4'h0;
    wr(`TCX_OFF_CTRL, 8'h00);
    chk("strobe resp", {30'h0, rr}, 32'h0);
    rc("no strobe", `TCX_OFF_CTRL, 8'hbf);
    s_axi_wstrb <= 4'hf;
    wr(4'h2, 8'h00);
    chk("wr unmapped", {30'h0, rr}, 32'h2);
    sleepMode <= 1'b1;
    repeat (8) @(negedge core_clk); // oscillator start-up wait
    chk("osc run", {31'h0, crystalOscRunning}, 32'h1);
    chk("pin read", {30'h0, portReadValue}, 32'h0);
    chk("pin input", {30'h0, portPinInputOnly}, 32'h3);
    $display("test control done");
    wr(`TCX_OFF_CTRL, 8'h00);
    chk("pin follow", {30'h0, portReadValue}, 32'h2);
    chk("pin dir", {30'h0, portPinInputOnly}, 32'h2);
    wr(`TCX_OFF_HIGH, 8'hff);
    wr(`TCX_OFF_LOW, 8'hfd);
    wr(`TCX_OFF_FLAG, 8'h02);
    repeat (20) @(negedge core_clk);
    chk("stopped", {16'h0, countValue}, 32'hfffd);
    rc("high narrow", `TCX_OFF_HIGH, 8'hff);
    wr(`TCX_OFF_CTRL, 8'h01);
    repeat (40) @(negedge core_clk);
    wr(`TCX_OFF_CTRL, 8'h00);
    chk("wrapped", {24'h0, countValue[15:8]}, 32'h0);
    chk("irq", {31'h0, overflowIrq}, 32'h1);
    rc("flag", `TCX_OFF_FLAG, 8'h03);
    $display("test overflow done");
    wr(`TCX_OFF_CTRL, 8'h80);
    wr(`TCX_OFF_HIGH, 8'h12);
    chk("high held", {24'h0, countValue[15:8]}, 32'h0);
    wr(`TCX_OFF_LOW, 8'h34);
    chk("wide write", {16'h0, countValue}, 32'h1234);
    wr(`TCX_OFF_HIGH, 8'h56);
    rc("buffer", `TCX_OFF_HIGH, 8'h56);
    rc("low", `TCX_OFF_LOW, 8'h34);
    rc("snap", `TCX_OFF_HIGH, 8'h12);
    $display("test wide done");
    for (int ps = 0; ps < 4; ps++) begin
      wr(`TCX_OFF_CTRL, {2'h0, ps[1:0], 4'h1});
      wr(`TCX_OFF_LOW, 8'h00);
      c0 = countValue;
      repeat (256) @(negedge core_clk);
      rd = {16'h0, countValue - c0};
      chk("rate", {31'h0, rd + 1 >= (64 >> ps) && rd <= (64 >> ps) + 1}, 32'h1);
    end
    for (int ns = 0; ns < 2; ns++) begin
      wr(`TCX_OFF_CTRL, {5'h0, ns[0], 2'h3});
      c0 = countValue;
      repeat (6) begin
        repeat (8) @(posedge core_clk);
        extCountClockPin <= ~extCountClockPin;
      end
      repeat (8) @(negedge core_clk);
      chk("ext edges", {16'h0, countValue - c0}, 32'h3);
    end
    $display("test sources done");
    wr(`TCX_OFF_CTRL, 8'h00);
    wr(`TCX_OFF_HIGH, 8'h00);
    wr(`TCX_OFF_LOW, 8'h00);
    wr(`TCX_OFF_FLAG, 8'h02);
    @(posedge core_clk);
    compareModeField <= `TCX_CMP_TRIG_MODE;
    period <= 16'h0005;
    armed <= 1'b1;
    wr(`TCX_OFF_CTRL, 8'h01); // timer mode while trigger resets are used
    c0 = 16'h0;
    nConv = 0;
    repeat (200) begin
      @(negedge core_clk);
      if (countValue > c0) c0 = countValue;
      nConv += conversionStart;
    end
    chk("period max", {16'h0, c0}, 32'h5);
    chk("conversions", {31'h0, nConv >= 6}, 32'h1);
    @(posedge core_clk);
    armed <= 1'b0;
    wr(`TCX_OFF_CTRL, 8'h00);
    rc("no flag", `TCX_OFF_FLAG, 8'h02);
    $display("test trigger done");
    end_of_test();
  end
endmodule
